// >>> shared/sfrm_pkg.sv
// Purpose: constants and types for the supply fault response manager
// Assumes: 200 MHz core clock, AXI4-Lite register access
// Notes: response word layout is local to this block
package sfrm_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned T_OV_BG_NS = 2000;
    localparam int unsigned OV_BG_CYC = T_OV_BG_NS * CLK_MHZ / 1000;
    localparam int unsigned T_10US_NS = 10000;
    localparam int unsigned CYC_10US = T_10US_NS * CLK_MHZ / 1000;
    localparam int unsigned T_1MS_US = 1000;
    localparam int unsigned CYC_1MS = T_1MS_US * CLK_MHZ;
    localparam int unsigned OC_STEP_MS = 16;
    localparam logic [16:0] RETRY_MIN_MS = 17'h00078;
    localparam logic [16:0] RETRY_MAX_MS = 17'h147a8;
    localparam logic [15:0] TEMP_HI_C = 16'h0082;
    localparam logic [15:0] TEMP_LO_C = 16'h0078;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_RETRY = 8'h04;
    localparam logic [7:0] A_OVRSP = 8'h08;
    localparam logic [7:0] A_UVRSP = 8'h0c;
    localparam logic [7:0] A_OCRSP = 8'h10;
    localparam logic [7:0] A_TONRSP = 8'h14;
    localparam logic [7:0] A_VINRSP = 8'h18;
    localparam logic [7:0] A_TONLIM = 8'h1c;
    localparam logic [7:0] A_IINLIM = 8'h20;
    localparam logic [7:0] A_STATUS = 8'h24;
    localparam logic [7:0] A_CLEAR = 8'h28;
    localparam logic [7:0] A_CMLEV = 8'h2c;
    localparam logic [7:0] A_THR = 8'h30;

    // response word: [1:0] action, [4:2] deglitch steps
    localparam int unsigned ACT_LO = 0;
    localparam int unsigned ACT_HI = 1;
    localparam int unsigned DG_LO = 2;
    localparam int unsigned DG_HI = 4;
    localparam logic [1:0] ACT_IGNORE = 2'h0;
    localparam logic [1:0] ACT_LATCH = 2'h1;
    localparam logic [1:0] ACT_RETRY = 2'h2;
    localparam logic [1:0] ACT_LIMIT = 2'h3;

    // status bits
    localparam int unsigned ST_OV = 0;
    localparam int unsigned ST_UV = 1;
    localparam int unsigned ST_OC = 2;
    localparam int unsigned ST_TON = 3;
    localparam int unsigned ST_VIN = 4;
    localparam int unsigned ST_OT = 5;
    localparam int unsigned ST_IIN = 6;
    localparam int unsigned ST_CML = 7;
    localparam int unsigned ST_SUM = 8;
    localparam int unsigned ST_NVMOFF = 9;
    localparam int unsigned ST_OFF = 10;
    localparam int unsigned NSRC = 6;

    typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_LATCHED, CH_RETRY} sfrm_ch_t;
endpackage

// >>> hdl/sfrm_deglitch.sv
// Purpose: per-source fault qualifier with step-scaled deglitch
// Assumes: tick marks one step of the source's deglitch unit
// Notes: steps of zero qualify on the cycle after the raw fault
`timescale 1ns/1ps
module sfrm_deglitch
    import sfrm_pkg::*;
(
    // clock
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // fault
    input wire logic i_raw,
    input wire logic i_tick,
    input wire logic [2:0] i_steps,
    output logic o_fault
);
    typedef struct packed {
        logic [2:0] cnt;
        logic hit;
    } sfrm_dg_t;
    sfrm_dg_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (!i_raw) begin
            s_nxt.cnt = 3'h0;
            s_nxt.hit = 1'b0;
        end else if (s_r.cnt >= i_steps) begin
            s_nxt.hit = 1'b1;
        end else if (i_tick) begin
            s_nxt.cnt = s_r.cnt + 3'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_r <= '0;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    assign o_fault = s_r.hit;
endmodule

// >>> hdl/sfrm_top.sv
// Purpose: fault response manager for one regulator channel's faults
// Assumes: comparator and ADC inputs synchronous to i_sys_clk
// Notes: registers on AXI4-Lite; response words hold action, plus deglitch for ov, uv and oc only
`timescale 1ns/1ps

// Overview of operation
// [R01] overvoltage: top off, bottom on until clear
// [R02] overvoltage action never ignore
// [R03] overvoltage deglitch 0-7 steps of 10us
// [R04] undervoltage ignore, latch or retry, deglitched
// [R05] overcurrent limit, latch or retry, 16ms steps
// [R06] retry interval 120ms to 83.88s, 1ms
// [R07] retry repeats, latch stays off, ignore none
// [R08] currents from averaged ADC readings
// [R09] input current sum over limit raises warning
// [R10] rise timer starts with soft-start
// [R11] rise limit zero disables, 10us steps
// [R12] rise fault undeglitched, ignore latch retry
// [R13] software sets rise limit above rise time
// [R14] input overvoltage from ADC reading
// [R15] nvm off above 130C until 120C
// [R16] internal overtemp always acts, fixed limits
// [R17] host avoids nvm writes above 85C
// [R18] communication errors set cml, summary, alert
// [R19] ov uv thresholds from pins, nvm, bus
// [R20] dcr temperature adjusts control voltage ceiling
// [R21] output current uses resistance tempco
// [R22] alert holds until clear, reset, power
// [R23] run toggle clears channel faults
// [R24] retry restarts soft-start if fault gone
// [R25] response word holds action and deglitch
module sfrm_top
    import sfrm_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // axi4-lite write
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // axi4-lite read
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // channel control and sensors
    input wire logic i_run,
    input wire logic i_softstart_go,
    input wire logic i_ov_cmp,
    input wire logic i_uv_cmp,
    input wire logic [15:0] i_iout0_avg,
    input wire logic [15:0] i_iout1_avg,
    input wire logic [15:0] i_duty0,
    input wire logic [15:0] i_duty1,
    input wire logic [15:0] i_ioff0,
    input wire logic [15:0] i_ioff1,
    input wire logic [15:0] i_iout_lim,
    input wire logic [15:0] i_vin_adc,
    input wire logic [15:0] i_vin_ov_lim,
    input wire logic [15:0] i_die_temp,
    input wire logic [15:0] i_ext_temp,
    input wire logic [15:0] i_ith_base,
    input wire logic [15:0] i_dcr_tc,
    input wire logic i_dcr_sense,
    input wire logic [15:0] i_pin_ovuv,
    input wire logic [15:0] i_nvm_ovuv,
    input wire logic [1:0] i_ovuv_src,
    // communication errors from the serial front end
    input wire logic i_pec_bad,
    input wire logic i_cmd_unsup,
    input wire logic i_data_bad,
    // outputs
    output logic o_top_gate_en,
    output logic o_bottom_gate_drive,
    output logic o_switch_en,
    output logic o_softstart_req,
    output logic o_alert_n,
    output logic o_nvm_en,
    output logic [15:0] o_error_amp_control_voltage,
    output logic [15:0] o_ovuv_thr
);
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    localparam logic [1:0] SRC_PIN = 2'h0;
    localparam logic [1:0] SRC_NVM = 2'h1;

    typedef struct packed {
        logic aw_f, w_f, bv, rv;
        logic [7:0] awa;
        logic [31:0] wd;
        logic [1:0] br, rr;
        logic [31:0] rd;
        logic [16:0] retry;
        logic [4:0] rsp_ov, rsp_uv, rsp_oc, rsp_ton, rsp_vin;
        logic [15:0] ton_lim, iin_lim, thr;
        logic cfg_pec;
        logic [10:0] st;
        sfrm_ch_t ch;
        logic [15:0] c10, tonc;
        logic [27:0] c1ms;
        logic [16:0] rcnt;
        logic [3:0] c16;
        logic [8:0] ovc;
        logic bg, ton_on, run_d, nvm_off, latch_retry;
        logic [15:0] error_amp_control_voltage;
    } sfrm_st_t;
    sfrm_st_t s_r, s_nxt;

    // deglitch and step ticks
    logic tick10, tick1ms, tick16;
    logic ov_q, uv_q, oc_q;
    logic [31:0] iin_sum;
    logic [31:0] ith_adj;
    logic oc_raw, vin_raw, ot_raw, ton_fault, cml_ev;
    logic aw_go, w_go, ar_go;

    function automatic logic [1:0] act_of(input logic [4:0] w);
        act_of = w[ACT_HI:ACT_LO];
    endfunction

    function automatic logic [31:0] prod(input logic [15:0] a, input logic [15:0] b);
        prod = a * b;
    endfunction

    assign tick10 = (s_r.c10 == 16'(CYC_10US - 1));
    assign tick1ms = (s_r.c1ms == 28'(CYC_1MS - 1));
    assign tick16 = tick1ms && (s_r.c16 == 4'(OC_STEP_MS - 1));
    // averaged readings feed the comparisons; see [R08]
    assign oc_raw = (i_iout0_avg > i_iout_lim);
    // input current estimate; see [R09]
    assign iin_sum = 32'(prod(i_iout0_avg, i_duty0) >> 16) + 32'(prod(i_iout1_avg, i_duty1) >> 16)
                   + 32'(i_ioff0) + 32'(i_ioff1);
    assign vin_raw = (i_vin_adc > i_vin_ov_lim); // see [R14]
    assign ot_raw = (i_die_temp > TEMP_HI_C); // see [R16]
    // rise timer, limit zero disables; see [R11] [R10]
    assign ton_fault = s_r.ton_on && (s_r.ton_lim != 16'h0) && (s_r.tonc >= s_r.ton_lim);
    assign cml_ev = (i_pec_bad && s_r.cfg_pec) || i_cmd_unsup || i_data_bad; // see [R18]
    // dcr compensation with tempco; see [R20] [R21]
    assign ith_adj = prod(i_ith_base, 16'(16'h8000 + prod(i_dcr_tc, i_ext_temp)));

    // see [R03] [R04] [R05] [R25]
    sfrm_deglitch u_dg_ov (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce), .i_raw(i_ov_cmp),
        .i_tick(tick10), .i_steps(s_r.rsp_ov[DG_HI:DG_LO]), .o_fault(ov_q));
    sfrm_deglitch u_dg_uv (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce), .i_raw(i_uv_cmp),
        .i_tick(tick10), .i_steps(s_r.rsp_uv[DG_HI:DG_LO]), .o_fault(uv_q));
    sfrm_deglitch u_dg_oc (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce), .i_raw(oc_raw),
        .i_tick(tick16), .i_steps(s_r.rsp_oc[DG_HI:DG_LO]), .o_fault(oc_q));

    // no handshake while frozen, or a taken item would be lost
    assign aw_go = i_ce && i_awvalid && !s_r.aw_f && !s_r.bv;
    assign w_go = i_ce && i_wvalid && !s_r.w_f && !s_r.bv;
    assign ar_go = i_ce && i_arvalid && !s_r.rv;

    always_comb begin
        logic [NSRC-1:0] shut, latch;
        logic [ST_CML:ST_OV] setv;
        logic [1:0] a;
        logic [7:0] ad;
        logic [31:0] wd;
        shut = '0;
        latch = '0;
        a = 2'h0;
        ad = 8'h0;
        wd = 32'h0;
        setv = '0;
        s_nxt = s_r;
        // step counters
        s_nxt.c10 = tick10 ? 16'h0 : s_r.c10 + 16'h1;
        s_nxt.c1ms = tick1ms ? 28'h0 : s_r.c1ms + 28'h1;
        if (tick1ms) begin
            s_nxt.c16 = (s_r.c16 == 4'(OC_STEP_MS - 1)) ? 4'h0 : s_r.c16 + 4'h1;
        end
        // bottom gate after detect delay, held while ov; see [R01]
        s_nxt.ovc = i_ov_cmp ? ((s_r.ovc < 9'(OV_BG_CYC)) ? s_r.ovc + 9'h1 : s_r.ovc) : 9'h0;
        s_nxt.bg = i_ov_cmp && (s_r.ovc >= 9'(OV_BG_CYC - 1));
        // nvm hysteresis; see [R15]
        if (i_die_temp > TEMP_HI_C) begin
            s_nxt.nvm_off = 1'b1;
        end else if (i_die_temp <= TEMP_LO_C) begin
            s_nxt.nvm_off = 1'b0;
        end
        s_nxt.error_amp_control_voltage = i_dcr_sense ? ith_adj[30:15] : i_ith_base;
        // action per source; see [R07] [R12]
        a = act_of(s_r.rsp_ov);
        shut[0] = ov_q && (a == ACT_LATCH || a == ACT_RETRY); // see [R02]
        latch[0] = a == ACT_LATCH;
        a = act_of(s_r.rsp_uv);
        shut[1] = uv_q && !s_r.ton_on && s_r.ch == CH_RUN && (a == ACT_LATCH || a == ACT_RETRY);
        latch[1] = a == ACT_LATCH;
        a = act_of(s_r.rsp_oc);
        shut[2] = oc_q && (a == ACT_LATCH || a == ACT_RETRY); // see [R05]
        latch[2] = a == ACT_LATCH;
        a = act_of(s_r.rsp_ton);
        shut[3] = ton_fault && (a == ACT_LATCH || a == ACT_RETRY);
        latch[3] = a == ACT_LATCH;
        a = act_of(s_r.rsp_vin);
        shut[4] = vin_raw && (a == ACT_LATCH || a == ACT_RETRY);
        latch[4] = a == ACT_LATCH;
        shut[5] = ot_raw;
        latch[5] = 1'b0;
        // sticky status, set wins over clear; see [R22]
        setv[ST_OV] = ov_q;
        setv[ST_UV] = uv_q && s_r.ch == CH_RUN && !s_r.ton_on;
        setv[ST_OC] = oc_q;
        setv[ST_TON] = ton_fault;
        setv[ST_VIN] = vin_raw;
        setv[ST_OT] = ot_raw;
        setv[ST_IIN] = iin_sum > 32'(s_r.iin_lim); // see [R09]
        setv[ST_CML] = cml_ev;
        s_nxt.st[ST_CML:ST_OV] = s_r.st[ST_CML:ST_OV] | setv;
        s_nxt.st[ST_NVMOFF] = s_nxt.nvm_off;
        s_nxt.st[ST_OFF] = (s_r.ch == CH_LATCHED) || (s_r.ch == CH_RETRY);
        // rise timer; see [R10]
        if (s_r.ton_on && tick10) s_nxt.tonc = s_r.tonc + 16'h1;
        if (s_r.ton_on && (!i_uv_cmp || ton_fault)) s_nxt.ton_on = 1'b0;
        // channel sequencing
        s_nxt.run_d = i_run;
        case (s_r.ch)
            CH_IDLE: begin
                if (i_run && i_softstart_go) begin
                    s_nxt.ch = CH_RUN;
                    s_nxt.ton_on = 1'b1;
                    s_nxt.tonc = 16'h0;
                end
            end
            CH_RUN: begin
                if (!i_run) begin
                    s_nxt.ch = CH_IDLE;
                    s_nxt.ton_on = 1'b0;
                end else if (|shut) begin
                    s_nxt.ch = (|(shut & latch)) ? CH_LATCHED : CH_RETRY;
                    s_nxt.rcnt = 17'h0;
                    s_nxt.ton_on = 1'b0;
                end
            end
            CH_LATCHED: begin
                if (!i_run) s_nxt.ch = CH_IDLE;
            end
            CH_RETRY: begin
                // restart only when interval elapsed and fault gone; see [R24] [R06]
                if (!i_run) begin
                    s_nxt.ch = CH_IDLE;
                end else if (tick1ms && s_r.rcnt < s_r.retry) begin
                    s_nxt.rcnt = s_r.rcnt + 17'h1;
                end else if (s_r.rcnt >= s_r.retry && !(|shut) && !ov_q && !ot_raw
                             && !vin_raw && !oc_q) begin
                    s_nxt.ch = CH_RUN;
                    s_nxt.ton_on = 1'b1;
                    s_nxt.tonc = 16'h0;
                end
            end
            default: s_nxt.ch = CH_IDLE;
        endcase
        // run toggle clears channel faults; see [R23]
        if (i_run && !s_r.run_d) begin
            s_nxt.st[ST_TON:ST_OV] = setv[ST_TON:ST_OV];
        end
        // axi write
        if (aw_go) begin
            s_nxt.aw_f = 1'b1;
            s_nxt.awa = i_awaddr;
        end
        if (w_go) begin
            s_nxt.w_f = 1'b1;
            s_nxt.wd = i_wdata;
        end
        if (s_r.aw_f && s_r.w_f && !s_r.bv) begin
            ad = s_r.awa;
            wd = s_r.wd;
            s_nxt.aw_f = 1'b0;
            s_nxt.w_f = 1'b0;
            s_nxt.bv = 1'b1;
            s_nxt.br = RESP_OK;
            if (ad == A_CTRL) begin
                s_nxt.cfg_pec = wd[0];
            end else if (ad == A_RETRY) begin
                if (wd[16:0] >= RETRY_MIN_MS && wd[16:0] <= RETRY_MAX_MS) s_nxt.retry = wd[16:0];
                else s_nxt.br = RESP_ERR;
            end else if (ad == A_OVRSP) begin
                if (wd[ACT_HI:ACT_LO] != ACT_IGNORE) s_nxt.rsp_ov = wd[DG_HI:0];
                else s_nxt.br = RESP_ERR;
            end else if (ad == A_UVRSP) begin
                s_nxt.rsp_uv = wd[DG_HI:0];
            end else if (ad == A_OCRSP) begin
                if (wd[ACT_HI:ACT_LO] != ACT_IGNORE) s_nxt.rsp_oc = wd[DG_HI:0];
                else s_nxt.br = RESP_ERR;
            end else if (ad == A_TONRSP) begin
                s_nxt.rsp_ton = {3'h0, wd[ACT_HI:ACT_LO]};
            end else if (ad == A_VINRSP) begin
                s_nxt.rsp_vin = {3'h0, wd[ACT_HI:ACT_LO]};
            end else if (ad == A_TONLIM) begin
                s_nxt.ton_lim = wd[15:0];
            end else if (ad == A_IINLIM) begin
                s_nxt.iin_lim = wd[15:0];
            end else if (ad == A_CLEAR) begin
                s_nxt.st[ST_CML:ST_OV] = (s_nxt.st[ST_CML:ST_OV] & ~wd[ST_CML:ST_OV]) | setv;
            end else if (ad == A_THR) begin
                s_nxt.thr = wd[15:0]; // see [R19]
            end else begin
                s_nxt.br = RESP_ERR;
            end
        end
        if (s_r.bv && i_bready) s_nxt.bv = 1'b0;
        // axi read
        if (ar_go) begin
            s_nxt.rv = 1'b1;
            s_nxt.rr = RESP_OK;
            if (i_araddr == A_CTRL) s_nxt.rd = {31'h0, s_r.cfg_pec};
            else if (i_araddr == A_RETRY) s_nxt.rd = {15'h0, s_r.retry};
            else if (i_araddr == A_OVRSP) s_nxt.rd = {27'h0, s_r.rsp_ov};
            else if (i_araddr == A_UVRSP) s_nxt.rd = {27'h0, s_r.rsp_uv};
            else if (i_araddr == A_OCRSP) s_nxt.rd = {27'h0, s_r.rsp_oc};
            else if (i_araddr == A_TONRSP) s_nxt.rd = {27'h0, s_r.rsp_ton};
            else if (i_araddr == A_VINRSP) s_nxt.rd = {27'h0, s_r.rsp_vin};
            else if (i_araddr == A_TONLIM) s_nxt.rd = {16'h0, s_r.ton_lim};
            else if (i_araddr == A_IINLIM) s_nxt.rd = {16'h0, s_r.iin_lim};
            else if (i_araddr == A_STATUS) s_nxt.rd = {21'h0, s_r.st[ST_OFF:ST_NVMOFF],
                                                      |s_r.st[ST_CML:ST_OV], s_r.st[ST_CML:0]};
            else if (i_araddr == A_THR) s_nxt.rd = {16'h0, s_r.thr};
            else begin
                s_nxt.rd = 32'h0;
                s_nxt.rr = RESP_ERR;
            end
        end
        if (s_r.rv && i_rready) s_nxt.rv = 1'b0;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_r <= '0;
            s_r.retry <= RETRY_MIN_MS;
            s_r.rsp_ov <= {3'h0, ACT_LATCH};
            s_r.rsp_oc <= {3'h0, ACT_LIMIT};
            s_r.ch <= CH_IDLE;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    assign o_awready = aw_go;
    assign o_wready = w_go;
    assign o_bvalid = s_r.bv;
    assign o_bresp = s_r.br;
    assign o_arready = ar_go;
    assign o_rvalid = s_r.rv;
    assign o_rdata = s_r.rd;
    assign o_rresp = s_r.rr;
    assign o_switch_en = (s_r.ch == CH_RUN);
    assign o_top_gate_en = (s_r.ch == CH_RUN) && !i_ov_cmp; // see [R01]
    assign o_bottom_gate_drive = s_r.bg;
    assign o_softstart_req = s_r.ton_on;
    // alert low while any fault bit stands; see [R22] [R18] [R09]
    assign o_alert_n = ~(|s_r.st[ST_CML:ST_OV]);
    assign o_nvm_en = !s_r.nvm_off;
    assign o_error_amp_control_voltage = s_r.error_amp_control_voltage;
    assign o_ovuv_thr = (i_ovuv_src == SRC_PIN) ? i_pin_ovuv :
                        (i_ovuv_src == SRC_NVM) ? i_nvm_ovuv : s_r.thr; // see [R19]

    bg_delay_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [R01]
        $rose(s_r.bg) |-> $past(i_ov_cmp, 2));
    ov_ignore_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [R02]
        act_of(s_r.rsp_ov) != ACT_IGNORE);
    nvm_hyst_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [R15]
        i_ce && i_die_temp > TEMP_HI_C |=> !o_nvm_en);
    ton_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [R11]
        s_r.ton_lim == 16'h0 |-> !ton_fault);
    cml_alert_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [R18]
        i_ce && i_cmd_unsup |=> !o_alert_n);
    latch_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [R07]
        s_r.ch == CH_LATCHED && i_run |=> s_r.ch == CH_LATCHED);
    retry_min_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [R06]
        s_r.retry >= RETRY_MIN_MS && s_r.retry <= RETRY_MAX_MS);
    ot_shut_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see [R16]
        i_ce && ot_raw && s_r.ch == CH_RUN && i_run |=> s_r.ch == CH_RETRY || s_r.ch == CH_LATCHED);
endmodule

// >>> verif/sfrm_stage_model.sv
// Purpose: power stage and sense model driving comparator levels
// Assumes: output reaches the uv limit RISE cycles after switching starts
// Notes: the overvoltage level is commanded by the bench
`timescale 1ns/1ps
module sfrm_stage_model #(
    parameter int RISE = 4000,
    parameter int TON_DLY = 2
) (
    // control
    input wire logic i_sys_clk,
    input wire logic i_run,
    input wire logic i_switch_en,
    input wire logic i_ov_req,
    // comparators
    output logic o_ov_cmp,
    output logic o_uv_cmp,
    output logic o_softstart_go
);
    int cnt = 0;
    int dly = 0;
    always @(posedge i_sys_clk) begin
        cnt <= i_switch_en ? cnt + 1 : 0;
        dly <= i_run ? ((dly < TON_DLY) ? dly + 1 : dly) : 0;
    end
    // soft-start begins once the turn-on delay has run out
    assign o_softstart_go = i_run && (dly >= TON_DLY);
    // output collapses below the uv limit whenever switching stops
    assign o_uv_cmp = cnt < RISE;
    assign o_ov_cmp = i_ov_req;
endmodule

// >>> verif/sfrm_top_tb.sv
// Purpose: self-checking bench for the fault response manager
// Assumes: AXI4-Lite master, stage model on the far side
// Notes: bus answers are checked from queues by a monitor
`timescale 1ns/1ps
module sfrm_top_tb;
    import sfrm_pkg::*;
    localparam logic [33:0] FM = 34'h3ffffffff;
    logic clk = 0, rst = 1, run = 0, ovq = 0, dcr = 1;
    logic [7:0] awa = 0, ara = 0;
    logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, pec = 0, uns = 0, dbad = 0;
    logic [31:0] wd = 0, rdt;
    logic [15:0] io0 = 0, io1 = 0, du = 16'h8000, off = 16'h0000, tmp = 16'h0019;
    logic [15:0] ilim = 16'hffff;
    logic [15:0] tc = 0, dt = 16'h0019, pinv = 16'h0a0a, nvmv = 16'h0b0b, ev, thr;
    logic [1:0] src = 0, br, rr, bq[$];
    logic awr, wrdy, bv, arr, rv, ovc, uvc, ssg, tg, bg, swe, alr, nvm, ssr;
    logic [33:0] rq_e[$], rq_m[$], m;
    int n_mismatch = 0, check_count = 0, seed = 78148, x0, x1, lim;

    initial forever #2.5 clk = ~clk;

    sfrm_stage_model u_stage (.i_sys_clk(clk), .i_run(run), .i_switch_en(swe), .i_ov_req(ovq),
        .o_ov_cmp(ovc), .o_uv_cmp(uvc), .o_softstart_go(ssg));

    sfrm_top u_dut (.i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_awaddr(awa),
        .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv),
        .o_wready(wrdy), .o_bresp(br), .o_bvalid(bv), .i_bready(bry), .i_araddr(ara),
        .i_arvalid(arv), .o_arready(arr), .o_rdata(rdt), .o_rresp(rr), .o_rvalid(rv),
        .i_rready(rry), .i_run(run), .i_softstart_go(ssg), .i_ov_cmp(ovc), .i_uv_cmp(uvc),
        .i_iout0_avg(io0), .i_iout1_avg(io1), .i_duty0(du), .i_duty1(du), .i_ioff0(off),
        .i_ioff1(off), .i_iout_lim(ilim), .i_vin_adc(16'h0000),
        .i_vin_ov_lim(16'hffff), .i_die_temp(dt), .i_ext_temp(tmp), .i_ith_base(16'h1000),
        .i_dcr_tc(tc), .i_dcr_sense(dcr), .i_pin_ovuv(pinv), .i_nvm_ovuv(nvmv),
        .i_ovuv_src(src), .i_pec_bad(pec), .i_cmd_unsup(uns), .i_data_bad(dbad),
        .o_top_gate_en(tg), .o_bottom_gate_drive(bg), .o_switch_en(swe),
        .o_softstart_req(ssr), .o_alert_n(alr), .o_nvm_en(nvm),
        .o_error_amp_control_voltage(ev), .o_ovuv_thr(thr));

    task chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        @(posedge clk);
        bq.push_back(e);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bry <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wrdy) wv <= 0;
            if (bv) break;
        end
        bry <= 0;
        if (n == 100) begin
            n_mismatch++;
            conclude();
        end
    endtask

    task rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] mk);
        int n;
        @(posedge clk);
        rq_e.push_back(e);
        rq_m.push_back(mk);
        ara <= a;
        arv <= 1;
        rry <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arr) arv <= 0;
            if (rv) break;
        end
        rry <= 0;
        if (n == 100) begin
            n_mismatch++;
            conclude();
        end
    endtask

    // bus answers are compared against the oldest expectation
    always @(posedge clk) begin
        if (bv && bry) chk("bresp", br, bq.pop_front());
        if (rv && rry) begin
            m = rq_m.pop_front();
            chk("rdata", {rr, rdt} & m, rq_e.pop_front() & m);
        end
    end

    initial begin
        cyc(12);
        rst <= 0;
        cyc(2);
        chk("alert", alr, 1);
        rd(A_RETRY, 34'h78, FM);
        rd(8'hfc, 34'h200000000, FM);
        wr(A_RETRY, 32'h77, 2'h2);
        wr(A_RETRY, 32'h147a9, 2'h2);
        wr(A_RETRY, 32'h147a8, 2'h0);
        rd(A_RETRY, 34'h147a8, FM);
        wr(A_OVRSP, 32'h0, 2'h2);
        wr(A_OCRSP, 32'h0, 2'h2);
        wr(A_OCRSP, 32'h1f, 2'h0);
        rd(A_OCRSP, 34'h1f, 34'h1f);
        wr(A_OCRSP, 32'h3, 2'h0);
        wr(A_THR, 32'h1234, 2'h0);
        for (int i = 0; i < 4; i++) begin
            src <= i[1:0];
            cyc(2);
            chk("thr", thr, i == 0 ? pinv : i == 1 ? nvmv : 16'h1234);
        end
        tc <= 16'h0002;
        tmp <= 16'h0100;
        cyc(4);
        chk("ith", ev, 16'h1040);
        wr(A_TONRSP, 32'h1, 2'h0);
        run <= 1;
        cyc(3000);
        chk("switch", swe, 1);
        chk("ssreq", ssr, 1);
        run <= 0;
        wr(A_TONLIM, 32'h1, 2'h0);
        run <= 1;
        cyc(2200);
        chk("switch", swe, 0);
        rd(A_STATUS, 34'h8, 34'h8);
        chk("alert", alr, 0);
        run <= 0;
        wr(A_TONLIM, 32'h4, 2'h0);
        wr(A_CLEAR, 32'h7ff, 2'h0);
        run <= 1;
        cyc(6500);
        chk("switch", swe, 1);
        chk("ssreq", ssr, 0);
        ovq <= 1;
        cyc(2);
        chk("top", tg, 0);
        cyc(388);
        chk("bottom", bg, 0);
        cyc(20);
        chk("bottom", bg, 1);
        ovq <= 0;
        cyc(3);
        chk("bottom", bg, 0);
        chk("alert", alr, 0);
        cyc(50);
        chk("switch", swe, 0);
        rd(A_STATUS, 34'h1, 34'h1);
        run <= 0;
        cyc(3);
        run <= 1;
        cyc(6);
        chk("switch", swe, 1);
        rd(A_STATUS, 34'h0, 34'h1);
        pec <= 1;
        cyc(1);
        pec <= 0;
        rd(A_STATUS, 34'h0, 34'h80);
        uns <= 1;
        cyc(1);
        uns <= 0;
        rd(A_STATUS, 34'h180, 34'h180);
        wr(A_CTRL, 32'h1, 2'h0);
        wr(A_CLEAR, 32'h80, 2'h0);
        pec <= 1;
        cyc(1);
        pec <= 0;
        rd(A_STATUS, 34'h80, 34'h80);
        wr(A_CLEAR, 32'h80, 2'h0);
        dbad <= 1;
        cyc(1);
        dbad <= 0;
        rd(A_STATUS, 34'h80, 34'h80);
        x0 = $random(seed) & 32'h7fff;
        x1 = $random(seed) & 32'h7fff;
        io0 <= x0[15:0];
        io1 <= x1[15:0];
        off <= 16'h0003;
        lim = (x0 >> 1) + (x1 >> 1) + 6;
        wr(A_IINLIM, lim, 2'h0);
        wr(A_CLEAR, 32'h7ff, 2'h0);
        cyc(4);
        rd(A_STATUS, 34'h0, 34'h40);
        wr(A_IINLIM, lim - 1, 2'h0);
        cyc(4);
        rd(A_STATUS, 34'h40, 34'h40);
        chk("alert", alr, 0);
        ilim <= 16'h00ff;
        io0 <= 16'h0100;
        cyc(4);
        rd(A_STATUS, 34'h4, 34'h4);
        chk("switch", swe, 1);
        // nvm enable drops while the die is hot and returns at 120C
        dt <= 16'h0082;
        cyc(4);
        chk("nvm", nvm, 1);
        dt <= 16'h0083;
        cyc(4);
        chk("nvm", nvm, 0);
        rd(A_STATUS, 34'h20, 34'h20);
        dt <= 16'h0079;
        cyc(4);
        chk("nvm", nvm, 0);
        dt <= 16'h0078;
        cyc(4);
        chk("nvm", nvm, 1);
        conclude();
    end
endmodule
